// file: hw/chg_pkg.sv
/*
 * Constants, register layout and carrier types for the charger control block.
 * Assumes a single 125 MHz clock and an I2C slave front end in the same design.
 */
// Operation
// - Three modes: charge, boost, high impedance
// - High impedance turns charge and boost off
// - Linear pre-charge below short threshold, then switching
// - Terminate when current falls to termination setting
// - Termination enable bit gates current termination
// - Float target is 3.5 V plus 20 mV per step
// - Codes from limit upward saturate at 4.44 V
// - Host programs the fields over I2C
// - Recharge below float target minus hysteresis
// - Auto-start variant restarts on supply reset if weak
// - Write clearing disable or high-impedance restarts charge
package chg_pkg;
    localparam logic [7:0] CTRL0_IDX = 8'h00;
    localparam logic [7:0] CTRL1_IDX = 8'h01;
    localparam logic [7:0] FLOAT_IDX = 8'h02;
    localparam logic [7:0] CURR_IDX = 8'h04;
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h30;
    localparam logic [7:0] FLOAT_RST = 8'h08;
    localparam logic [7:0] CURR_RST = 8'h01;
    localparam int CTRL_BOOST_BIT = 0;
    localparam int CTRL_HIZ_BIT = 1;
    localparam int CTRL_DIS_BIT = 2;
    localparam int CTRL1_TERM_EN_BIT = 3;
    localparam logic [5:0] FLOAT_LIMIT_CODE = 6'h2f;
    localparam int FLOAT_BASE_MV = 3500;
    localparam int FLOAT_STEP_MV = 20;
    // Arbitrary bus address
    localparam logic [6:0] I2C_DEV_ADDR = 7'h35;

    typedef enum logic [4:0] {
        CHG_IDLE = 5'b00001,
        CHG_PRE = 5'b00010,
        CHG_CC = 5'b00100,
        CHG_CV = 5'b01000,
        CHG_DONE = 5'b10000
    } chg_phase_type;

    typedef enum logic [2:0] {
        MODE_HIZ = 3'b001,
        MODE_CHARGE = 3'b010,
        MODE_BOOST = 3'b100
    } chg_mode_type;

    // Digitised comparator results from the analog front end
    typedef struct packed {
        logic short_ok;
        logic weak_ok;
        logic cv_active;
        logic below_term;
        logic below_recharge;
        logic bus_por_ok;
    } chg_sense_type;

    typedef struct packed {
        logic linear_on;
        logic pwm_on;
        logic boost_on;
    } chg_power_type;
endpackage

// file: hw/chg_i2c_slave.sv
/*
 * Byte-oriented I2C slave: address, register pointer, data with auto increment.
 * Assumes scl and sda are already synchronous to clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module chg_i2c_slave (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o,
    output logic wr_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i,
    output logic stop_o
);
    logic scl_q, sda_q, active, is_read, ack_phase, drop;
    logic [3:0] bitcnt;
    logic [7:0] shreg, ptr;
    logic [1:0] byteno;
    wire scl_rise = scl_i && !scl_q;
    wire scl_fall = !scl_i && scl_q;
    wire start = scl_i && scl_q && sda_q && !sda_i;
    wire stop = scl_i && scl_q && !sda_q && sda_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            active <= 1'b0;
            is_read <= 1'b0;
            ack_phase <= 1'b0;
            drop <= 1'b0;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            byteno <= 2'h0;
            sda_oe_o <= 1'b0;
            wr_o <= 1'b0;
            wdata_o <= 8'h00;
            stop_o <= 1'b0;
        end else begin
            wr_o <= 1'b0;
            stop_o <= stop && active;
            if (start) begin
                active <= 1'b1;
                bitcnt <= 4'h0;
                byteno <= 2'h0;
                ack_phase <= 1'b0;
                is_read <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (stop) begin
                active <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (active && scl_rise && !ack_phase) begin
                shreg <= {shreg[6:0], sda_i};
                bitcnt <= bitcnt + 4'h1;
            end else if (active && scl_rise && ack_phase && is_read) begin
                drop <= sda_i;
            end else if (active && scl_fall) begin
                if (ack_phase) begin
                    ack_phase <= 1'b0;
                    bitcnt <= 4'h0;
                    if (is_read) begin
                        ptr <= ptr + 8'h1;
                        active <= !drop;
                    end
                    sda_oe_o <= is_read && !drop && !rdata_i[7];
                    shreg <= rdata_i;
                end else if (bitcnt == 4'h8) begin
                    ack_phase <= 1'b1;
                    if (is_read) begin
                        sda_oe_o <= 1'b0;
                    end else if (byteno == 2'h0) begin
                        if (shreg[7:1] == chg_pkg::I2C_DEV_ADDR) begin
                            is_read <= shreg[0];
                            sda_oe_o <= 1'b1;
                            byteno <= 2'h1;
                            drop <= 1'b0;
                        end else begin
                            active <= 1'b0;
                        end
                    end else begin
                        sda_oe_o <= 1'b1;
                        if (byteno == 2'h1) begin
                            ptr <= shreg;
                            byteno <= 2'h2;
                        end else begin
                            wr_o <= 1'b1;
                            wdata_o <= shreg;
                            ptr <= ptr + 8'h1;
                        end
                    end
                end else if (is_read) begin
                    sda_oe_o <= !shreg[7];
                end
            end
        end
    end

    assign addr_o = (wr_o) ? ptr - 8'h1 : ptr;
endmodule
`default_nettype wire

// file: hw/chg_ctrl.sv
/*
 * Charger control registers and charge sequencing.
 * Assumes comparator inputs are synchronous digital levels from the analog side.
 */
`timescale 1ns/10ps
`default_nettype none
module chg_ctrl #(
    parameter bit AUTO_START = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o,
    output logic sda_o,
    input wire chg_pkg::chg_sense_type sense_i,
    output chg_pkg::chg_power_type power_o,
    output chg_pkg::chg_mode_type mode_o,
    output chg_pkg::chg_phase_type phase_o,
    output logic [5:0] float_code_o,
    output logic [12:0] float_mv_o,
    output logic [2:0] charge_current_code_o,
    output logic [1:0] input_current_limit_code_o,
    output logic [2:0] termination_current_code_o,
    output logic [1:0] weak_battery_threshold_o
);
    logic [7:0] first_control_register_r, charge_control_one_r;
    logic [7:0] float_voltage_setting_r, charge_current_settings_r;
    logic [7:0] pend_data_r, pend_addr_r;
    logic pend_r, restart_r, por_q_r;
    logic wr, stop;
    logic [7:0] addr, wdata, rdata;
    logic [5:0] float_code_sat;
    chg_pkg::chg_phase_type phase_r, phase_nxt;
    chg_pkg::chg_mode_type mode_nxt;

    chg_i2c_slave u_i2c (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_oe_o(sda_oe_o),
        .wr_o(wr),
        .addr_o(addr),
        .wdata_o(wdata),
        .rdata_i(rdata),
        .stop_o(stop)
    );

    always_comb begin
        case (addr)
            chg_pkg::CTRL0_IDX: rdata = first_control_register_r;
            chg_pkg::CTRL1_IDX: rdata = charge_control_one_r;
            chg_pkg::FLOAT_IDX: rdata = float_voltage_setting_r;
            chg_pkg::CURR_IDX: rdata = charge_current_settings_r;
            default: rdata = 8'h00;
        endcase
    end

    // The last write of a transfer is held and committed at the stop condition
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
            pend_addr_r <= 8'h00;
            pend_data_r <= 8'h00;
        end else if (wr) begin
            pend_r <= 1'b1;
            pend_addr_r <= addr;
            pend_data_r <= wdata;
        end else if (stop) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            first_control_register_r <= chg_pkg::CTRL0_RST;
            charge_control_one_r <= chg_pkg::CTRL1_RST;
            float_voltage_setting_r <= chg_pkg::FLOAT_RST;
            charge_current_settings_r <= chg_pkg::CURR_RST;
            restart_r <= 1'b0;
        end else begin
            restart_r <= 1'b0;
            if (stop && pend_r) begin
                case (pend_addr_r)
                    chg_pkg::CTRL0_IDX: begin
                        first_control_register_r <= pend_data_r;
                        restart_r <= (first_control_register_r[chg_pkg::CTRL_DIS_BIT]
                            && !pend_data_r[chg_pkg::CTRL_DIS_BIT])
                            || (first_control_register_r[chg_pkg::CTRL_HIZ_BIT]
                            && !pend_data_r[chg_pkg::CTRL_HIZ_BIT]);
                    end
                    chg_pkg::CTRL1_IDX: charge_control_one_r <= pend_data_r;
                    chg_pkg::FLOAT_IDX: float_voltage_setting_r <= pend_data_r;
                    chg_pkg::CURR_IDX: charge_current_settings_r <= pend_data_r;
                    default: ;
                endcase
            end
        end
    end

    // Supply reset release edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            por_q_r <= 1'b0;
        end else begin
            por_q_r <= sense_i.bus_por_ok;
        end
    end

    wire por_clear = sense_i.bus_por_ok && !por_q_r;
    wire hiz = first_control_register_r[chg_pkg::CTRL_HIZ_BIT];
    wire boost = first_control_register_r[chg_pkg::CTRL_BOOST_BIT];
    wire disabled = first_control_register_r[chg_pkg::CTRL_DIS_BIT];
    wire start_ev = restart_r || (AUTO_START && por_clear && !sense_i.weak_ok);
    wire term_en = charge_control_one_r[chg_pkg::CTRL1_TERM_EN_BIT];

    // High impedance takes priority over boost
    always_comb begin
        if (hiz) begin
            mode_nxt = chg_pkg::MODE_HIZ;
        end else if (boost) begin
            mode_nxt = chg_pkg::MODE_BOOST;
        end else begin
            mode_nxt = chg_pkg::MODE_CHARGE;
        end
    end

    // Pre-charge until the battery clears the short threshold
    chg_pkg::chg_phase_type entry_phase;
    assign entry_phase = sense_i.short_ok ? chg_pkg::CHG_CC : chg_pkg::CHG_PRE;

    // Leaving charge mode or losing the supply drops back to idle
    always_comb begin
        phase_nxt = phase_r;
        if (mode_nxt != chg_pkg::MODE_CHARGE || disabled || !sense_i.bus_por_ok) begin
            phase_nxt = chg_pkg::CHG_IDLE;
        end else begin
            case (phase_r)
                chg_pkg::CHG_IDLE: begin
                    if (start_ev) begin
                        phase_nxt = entry_phase;
                    end
                end
                chg_pkg::CHG_PRE: begin
                    if (sense_i.short_ok) begin
                        phase_nxt = chg_pkg::CHG_CC;
                    end
                end
                chg_pkg::CHG_CC: begin
                    if (sense_i.cv_active) begin
                        phase_nxt = chg_pkg::CHG_CV;
                    end
                end
                chg_pkg::CHG_CV: begin
                    if (term_en && sense_i.below_term) begin
                        phase_nxt = chg_pkg::CHG_DONE;
                    end
                end
                chg_pkg::CHG_DONE: begin
                    if (sense_i.below_recharge || start_ev) begin
                        phase_nxt = entry_phase;
                    end
                end
                default: phase_nxt = chg_pkg::CHG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_r <= chg_pkg::CHG_IDLE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // Saturating float code
    always_comb begin
        if (float_voltage_setting_r[7:2] > chg_pkg::FLOAT_LIMIT_CODE) begin
            float_code_sat = chg_pkg::FLOAT_LIMIT_CODE;
        end else begin
            float_code_sat = float_voltage_setting_r[7:2];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            power_o <= '0;
            mode_o <= chg_pkg::MODE_HIZ;
            phase_o <= chg_pkg::CHG_IDLE;
            sda_o <= 1'b0;
        end else begin
            mode_o <= mode_nxt;
            phase_o <= phase_nxt;
            power_o.linear_on <= phase_nxt == chg_pkg::CHG_PRE;
            power_o.pwm_on <= phase_nxt == chg_pkg::CHG_CC || phase_nxt == chg_pkg::CHG_CV;
            power_o.boost_on <= mode_nxt == chg_pkg::MODE_BOOST;
            sda_o <= 1'b0;
        end
    end

    // Field mirrors; the float target resets to the value of code zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            float_code_o <= 6'h00;
            float_mv_o <= 13'(chg_pkg::FLOAT_BASE_MV);
            charge_current_code_o <= 3'h0;
            input_current_limit_code_o <= 2'h0;
            termination_current_code_o <= 3'h0;
            weak_battery_threshold_o <= 2'h0;
        end else begin
            float_code_o <= float_code_sat;
            float_mv_o <= 13'(chg_pkg::FLOAT_BASE_MV)
                + 13'(float_code_sat) * 13'(chg_pkg::FLOAT_STEP_MV);
            charge_current_code_o <= charge_current_settings_r[6:4];
            input_current_limit_code_o <= charge_control_one_r[7:6];
            termination_current_code_o <= charge_current_settings_r[2:0];
            weak_battery_threshold_o <= charge_control_one_r[5:4];
        end
    end
endmodule
`default_nettype wire

// file: dv/chg_ctrl_assertions.sv
/* Port checker for chg_ctrl.
   Assumes it is bound to chg_ctrl and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module chg_ctrl_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire chg_pkg::chg_sense_type sense_i,
    input wire chg_pkg::chg_power_type power_o,
    input wire chg_pkg::chg_mode_type mode_o,
    input wire chg_pkg::chg_phase_type phase_o,
    input wire logic [5:0] float_code_o,
    input wire logic [12:0] float_mv_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_MODE: assert property ($onehot(mode_o))
        else $error("mode not one-hot");
    AST_BOOST: assert property ((mode_o == chg_pkg::MODE_BOOST) [*2] |->
        !power_o.linear_on && !power_o.pwm_on) else $error("charge path on in boost");
    AST_HIZ: assert property ((mode_o == chg_pkg::MODE_HIZ) [*2] |-> power_o == '0)
        else $error("power on in high impedance");
    AST_LIN: assert property (power_o.linear_on |->
        !power_o.pwm_on && phase_o == chg_pkg::CHG_PRE) else $error("linear source misuse");
    AST_PRE_CC: assert property (phase_o == chg_pkg::CHG_PRE && sense_i.short_ok &&
        mode_o == chg_pkg::MODE_CHARGE |-> ##[1:4] phase_o == chg_pkg::CHG_CC)
        else $error("no switch to constant current");
    AST_DONE: assert property (phase_o == chg_pkg::CHG_DONE |->
        !power_o.pwm_on && !power_o.linear_on) else $error("charging after done");
    AST_MV: assert property (float_mv_o ==
        13'(chg_pkg::FLOAT_BASE_MV + chg_pkg::FLOAT_STEP_MV * int'(float_code_o)))
        else $error("float target wrong");
    AST_SAT: assert property (float_code_o <= chg_pkg::FLOAT_LIMIT_CODE)
        else $error("float code above limit");
    AST_RCH: assert property (phase_o == chg_pkg::CHG_DONE && sense_i.below_recharge &&
        mode_o == chg_pkg::MODE_CHARGE |-> ##[1:4] phase_o != chg_pkg::CHG_DONE)
        else $error("no recharge");
    C_PRE: cover property (phase_o == chg_pkg::CHG_PRE);
    C_DONE: cover property (phase_o == chg_pkg::CHG_DONE);
    C_BOOST: cover property (mode_o == chg_pkg::MODE_BOOST);
endmodule
`default_nettype wire

// file: dv/chg_host_model.sv
/* I2C host master model for the charger register link.
   Assumes a pulled-up SDA level is fed back on sda_i. */
`timescale 1ns/10ps
`default_nettype none
module chg_host_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic tick();
        repeat (4) @(posedge clk_i);
    endtask
    // Data changes while SCL low, sampled in SCL high
    task automatic bit_io(input logic b, output logic s);
        sda_oe_o <= !b;
        tick();
        scl_o <= 1'b1;
        tick();
        s = sda_i;
        tick();
        scl_o <= 1'b0;
        tick();
    endtask
    task automatic xfer(input logic [7:0] v, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) bit_io(v[i], r[i]);
        bit_io(1'b1, a);
    endtask
    task automatic start();
        sda_oe_o <= 1'b1;
        tick();
        scl_o <= 1'b0;
        tick();
    endtask
    task automatic stop();
        sda_oe_o <= 1'b1;
        tick();
        scl_o <= 1'b1;
        tick();
        sda_oe_o <= 1'b0;
        tick();
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic a0, a1, a2;
        start();
        xfer({chg_pkg::I2C_DEV_ADDR, 1'b0}, r, a0);
        xfer(p, r, a1);
        xfer(d, r, a2);
        stop();
        ok = !a0 && !a1 && !a2;
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic a0, a1, a2;
        start();
        xfer({chg_pkg::I2C_DEV_ADDR, 1'b0}, r, a0);
        xfer(p, r, a1);
        stop();
        start();
        xfer({chg_pkg::I2C_DEV_ADDR, 1'b1}, r, a2);
        ok = !a0 && !a1 && !a2;
        xfer(8'hff, d, a0);
        stop();
    endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
/* Self-checking bench for chg_ctrl.
   Assumes the host model and the bound port checker. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_i, rst_i, scl, h_oe, d_oe, sda;
    chg_pkg::chg_sense_type sense;
    chg_pkg::chg_power_type power;
    chg_pkg::chg_mode_type mode;
    chg_pkg::chg_phase_type phase;
    logic [5:0] fcode;
    logic [12:0] fmv;
    logic [2:0] cc, tc;
    logic [1:0] il, wb;
    int error_cnt = 0;
    int n_tests = 0;
    // Open-drain SDA with pull-up
    assign sda = !(h_oe | d_oe);
    chg_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_oe_o(d_oe),
        .sda_o(), .sense_i(sense), .power_o(power), .mode_o(mode), .phase_o(phase),
        .float_code_o(fcode), .float_mv_o(fmv), .charge_current_code_o(cc),
        .input_current_limit_code_o(il), .termination_current_code_o(tc),
        .weak_battery_threshold_o(wb));
    chg_host_model host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input bit ok, input string m);
        n_tests++;
        if (!ok) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic wph(input chg_pkg::chg_phase_type p);
        for (int i = 0; i < 60 && phase !== p; i++) @(posedge clk_i);
        chk(phase === p, "phase timeout");
        if (phase !== p) finish_test();
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic ok;
        host.wr(p, d, ok);
        chk(ok === 1'b1, "no ack");
        repeat (4) @(posedge clk_i);
    endtask
    task automatic rdc(input logic [7:0] p, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        host.rd(p, d, ok);
        chk(ok === 1'b1 && d === e, "read value");
    endtask
    task automatic t_reset();
        rdc(chg_pkg::CTRL0_IDX, chg_pkg::CTRL0_RST);
        rdc(chg_pkg::CTRL1_IDX, chg_pkg::CTRL1_RST);
        rdc(chg_pkg::FLOAT_IDX, chg_pkg::FLOAT_RST);
        rdc(chg_pkg::CURR_IDX, chg_pkg::CURR_RST);
        rdc(8'h03, 8'h00);
        chk(fcode === 6'h02 && fmv === 13'h0dd4, "float reset");
        chk(wb === 2'h3 && tc === 3'h1 && cc === 3'h0 && il === 2'h0, "fields reset");
        chk(phase === chg_pkg::CHG_IDLE && mode === chg_pkg::MODE_CHARGE, "idle");
    endtask
    task automatic t_charge();
        @(posedge clk_i);
        sense.bus_por_ok <= 1'b1;
        wph(chg_pkg::CHG_PRE);
        chk(power.linear_on === 1'b1 && power.pwm_on === 1'b0, "pre power");
        sense.short_ok <= 1'b1;
        wph(chg_pkg::CHG_CC);
        chk(power.pwm_on === 1'b1 && power.linear_on === 1'b0, "cc power");
        sense.cv_active <= 1'b1;
        wph(chg_pkg::CHG_CV);
        sense.below_term <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk(phase === chg_pkg::CHG_CV, "ended with termination off");
        wr(chg_pkg::CTRL1_IDX, 8'h38);
        wph(chg_pkg::CHG_DONE);
        chk(power.pwm_on === 1'b0, "done power");
        sense.below_recharge <= 1'b1;
        sense.below_term <= 1'b0;
        sense.cv_active <= 1'b0;
        wph(chg_pkg::CHG_CC);
        sense.below_recharge <= 1'b0;
    endtask
    task automatic t_float();
        logic [5:0] cs [6] = '{6'h00, 6'h01, 6'h2e, 6'h2f, 6'h30, 6'h3f};
        logic [5:0] e;
        foreach (cs[i]) begin
            e = (cs[i] > 6'h2f) ? 6'h2f : cs[i];
            wr(chg_pkg::FLOAT_IDX, {cs[i], 2'h0});
            chk(fcode === e && fmv === 13'(3500 + 20 * int'(e)), "float");
            rdc(chg_pkg::FLOAT_IDX, {cs[i], 2'h0});
        end
    endtask
    task automatic t_fields();
        wr(chg_pkg::CURR_IDX, 8'h75);
        wr(chg_pkg::CTRL1_IDX, 8'hc8);
        chk(cc === 3'h7 && tc === 3'h5 && il === 2'h3 && wb === 2'h0, "fields");
    endtask
    task automatic t_modes();
        logic [7:0] bs [2] = '{8'h02, 8'h04};
        foreach (bs[i]) begin
            sense.cv_active <= 1'b1;
            sense.below_term <= 1'b1;
            wph(chg_pkg::CHG_DONE);
            wr(chg_pkg::CTRL0_IDX, bs[i]);
            if (i == 0) chk(mode === chg_pkg::MODE_HIZ && power === '0, "hiz");
            if (i == 1) chk(phase === chg_pkg::CHG_IDLE && power === '0, "disabled");
            sense.cv_active <= 1'b0;
            sense.below_term <= 1'b0;
            wr(chg_pkg::CTRL0_IDX, 8'h00);
            wph(chg_pkg::CHG_CC);
        end
        wr(chg_pkg::CTRL0_IDX, 8'h01);
        chk(mode === chg_pkg::MODE_BOOST && power.pwm_on === 1'b0, "boost");
        wr(chg_pkg::CTRL0_IDX, 8'h00);
        chk(mode === chg_pkg::MODE_CHARGE && phase === chg_pkg::CHG_IDLE, "charge mode");
    endtask
    initial begin
        sense = '0;
        rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_reset();
        t_charge();
        t_float();
        t_fields();
        t_modes();
        finish_test();
    end
endmodule
bind chg_ctrl chg_ctrl_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .sense_i(sense_i),
    .power_o(power_o), .mode_o(mode_o), .phase_o(phase_o), .float_code_o(float_code_o),
    .float_mv_o(float_mv_o));
`default_nettype wire
